// File: hdl/driver_mode_pkg.sv
package driver_mode_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CHANNELS   = 4;
  localparam int TYPE_CHANS = 2;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 24;
  localparam int CLK_MHZ    = 125;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_FAIL_SAFE,
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_SLEEP1,
    MODE_SLEEP2
  } mode_type;

  // ----------------------------------------
  // Serial frame: command byte then data byte
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } serial_frame_type;

  localparam logic [7:0] CMD_SW_RESET = 8'hFF;
  localparam logic [7:0] CMD_CONTROL  = 8'h01;
  localparam logic [7:0] CMD_ON       = 8'h02;
  localparam logic [7:0] CMD_DIEN     = 8'h03;
  localparam logic [7:0] CMD_PWM      = 8'h04;
  localparam logic [7:0] CMD_TYPE     = 8'h05;
  localparam logic [7:0] CMD_LATCH    = 8'h06;
  localparam logic [7:0] CMD_CLEAR    = 8'h07;

  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_STANDBY_REQUEST_BIT_BIT   = 1;
  localparam int CTRL_UNLOCK_BIT = 2;

  localparam logic [3:0] FRAME_LAST = 4'hF;

  // ----------------------------------------
  // Serial registers
  // ----------------------------------------
  typedef struct packed {
    logic [CHANNELS-1:0]   serial_output_on_bits;
    logic [CHANNELS-1:0]   direct_input_enable_bits;
    logic [CHANNELS-1:0]   pwm_select_bits;
    logic [CHANNELS-1:0]   latch_select_bits;
    logic [TYPE_CHANS-1:0] channel_type_bits;
    logic                  enable_bit;
    logic                  standby_request_bit;
  } chan_regs_type;

  localparam chan_regs_type REGS_RESET = '0;

  // ----------------------------------------
  // Synchroniser lanes
  // ----------------------------------------
  localparam int SY_CSN    = 0;
  localparam int SY_SUPPLY = 1;
  localparam int SY_BATT   = 2;
  localparam int SY_DIN    = 3;
  localparam int SY_OT     = 7;
  localparam int SY_PL     = 11;
  localparam int SY_TGL    = 15;
  localparam int SYNC_W    = 16;

endpackage : driver_mode_pkg

// File: hdl/driver_mode_ctrl.sv
`timescale 1ns/1ns
module driver_mode_ctrl #(
  parameter int WATCHDOG_PERIOD_US = 100,
  parameter int WATCHDOG_CYCLES    = WATCHDOG_PERIOD_US * driver_mode_pkg::CLK_MHZ,
  parameter int WAKE_TIME_US       = 50,
  parameter int WAKE_CYCLES        = WAKE_TIME_US * driver_mode_pkg::CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic                                    ref_clk_i,
  input  wire logic                                    rstn_i,
  input  wire logic                                    ce_i,
  // Serial link
  input  wire logic                                    sclk_i,
  input  wire logic                                    mosi_i,
  input  wire logic                                    chip_select_low_i,
  // Supply monitors and protection
  input  wire logic                                    logic_supply_low_i,
  input  wire logic                                    battery_undervoltage_i,
  input  wire logic [driver_mode_pkg::CHANNELS-1:0]    overtemp_shutdown_i,
  input  wire logic [driver_mode_pkg::CHANNELS-1:0]    power_limit_shutdown_i,
  // Direct inputs
  input  wire logic [driver_mode_pkg::CHANNELS-1:0]    direct_input_i,
  // Channel drive
  output logic [driver_mode_pkg::CHANNELS-1:0]         channel_output_o,
  output logic [driver_mode_pkg::CHANNELS-1:0]         pwm_run_o,
  output logic [driver_mode_pkg::TYPE_CHANS-1:0]       light_diode_mode_o,
  // Status
  output driver_mode_pkg::mode_type                    mode_o,
  output logic                                         reset_status_o,
  output logic                                         battery_undervoltage_flag_o,
  output logic                                         serial_active_o,
  output logic                                         diag_available_o,
  output logic                                         current_sense_enable_o,
  output logic [driver_mode_pkg::CHANNELS-1:0]         latched_off_o
);
  import driver_mode_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // Link domain: frame receiver
  // ----------------------------------------
  logic [3:0]             bit_cnt_q;
  logic [FRAME_BITS-2:0]  shift_q;
  serial_frame_type       frame_q;
  logic                   frame_tgl_q;
  logic                   frame_done;

  assign frame_done = (bit_cnt_q == FRAME_LAST);

  // The counter restarts whenever chip select is released.
  always_ff @(posedge sclk_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q     <= '0;
      frame_q     <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[FRAME_BITS-3:0], mosi_i};
      if (frame_done) begin
        frame_q     <= {shift_q, mosi_i};
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] filt_q;

  assign async_in = {frame_tgl_q, power_limit_shutdown_i, overtemp_shutdown_i,
                     direct_input_i, battery_undervoltage_i, logic_supply_low_i,
                     chip_select_low_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi]   <= (gi == SY_CSN);
          s2_q[gi]   <= (gi == SY_CSN);
          s3_q[gi]   <= (gi == SY_CSN);
          filt_q[gi] <= (gi == SY_CSN);
        end else if (ce_i) begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Decoded inputs
  // ----------------------------------------
  logic                csn_low;
  logic                supply_low;
  logic                batt_low;
  logic [CHANNELS-1:0] din;
  logic [CHANNELS-1:0] shut;
  logic                csn_prev_q;
  logic                tgl_prev_q;
  logic                csn_edge;
  logic                frame_evt;

  assign csn_low    = ~filt_q[SY_CSN];
  assign supply_low = filt_q[SY_SUPPLY];
  assign batt_low   = filt_q[SY_BATT];
  assign din        = filt_q[SY_DIN +: CHANNELS];
  assign shut       = filt_q[SY_OT +: CHANNELS] | filt_q[SY_PL +: CHANNELS];
  assign csn_edge   = csn_prev_q != filt_q[SY_CSN];
  assign frame_evt  = tgl_prev_q != filt_q[SY_TGL];

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  mode_type mode_q;
  mode_type mode_d;
  logic     serial_on;
  logic     accept;
  logic     sw_reset;
  logic     ctrl_wr;
  logic     req_en;
  logic     req_standby_request_bit;
  logic     req_unlock;
  logic     go_normal;
  logic     go_standby;
  logic     clear_regs;

  assign serial_on  = (mode_q == MODE_FAIL_SAFE) || (mode_q == MODE_NORMAL);
  assign accept     = frame_evt && serial_on;
  assign sw_reset   = accept && (frame_q.cmd == CMD_SW_RESET);
  assign ctrl_wr    = accept && (frame_q.cmd == CMD_CONTROL);
  assign req_en     = frame_q.data[CTRL_EN_BIT];
  assign req_standby_request_bit   = frame_q.data[CTRL_STANDBY_REQUEST_BIT_BIT];
  assign req_unlock = frame_q.data[CTRL_UNLOCK_BIT];

  logic unlock_q;

  assign go_normal  = ctrl_wr && unlock_q && !req_standby_request_bit && req_en;
  assign go_standby = ctrl_wr && unlock_q && req_standby_request_bit && !req_en;

  assign clear_regs = (mode_q == MODE_RESET) || (mode_q == MODE_SLEEP1) || sw_reset;

  // ----------------------------------------
  // Chip select timers
  // ----------------------------------------
  logic [CNT_W-1:0] wdog_q;
  logic [CNT_W-1:0] wake_q;
  logic             wdog_timeout;
  logic             wake_hit;
  logic             asleep_link;

  assign wdog_timeout = (wdog_q == CNT_W'(WATCHDOG_CYCLES - 1));
  assign asleep_link  = (mode_q == MODE_STANDBY) || (mode_q == MODE_SLEEP2);
  assign wake_hit     = csn_low && (wake_q == CNT_W'(WAKE_CYCLES));

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wdog_q <= '0;
      wake_q <= '0;
    end else if (ce_i) begin
      if ((mode_q != MODE_NORMAL) || csn_edge) begin
        wdog_q <= '0;
      end else if (!wdog_timeout) begin
        wdog_q <= wdog_q + CNT_W'(1);
      end
      if (!asleep_link || !csn_low) begin
        wake_q <= '0;
      end else if (!wake_hit) begin
        wake_q <= wake_q + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Mode transitions
  // ----------------------------------------
  always_comb begin
    mode_d = mode_q;
    if (supply_low) begin
      mode_d = MODE_RESET;
    end else begin
      case (mode_q)
        MODE_RESET: begin
          mode_d = MODE_FAIL_SAFE;
        end
        MODE_SLEEP1: begin
          mode_d = MODE_FAIL_SAFE;
        end
        MODE_FAIL_SAFE: begin
          if (go_normal) begin
            mode_d = MODE_NORMAL;
          end else if (go_standby) begin
            mode_d = MODE_STANDBY;
          end
        end
        MODE_NORMAL: begin
          if (sw_reset) begin
            mode_d = MODE_FAIL_SAFE;
          end else if (go_standby) begin
            mode_d = MODE_STANDBY;
          end else if (ctrl_wr && !req_en && !req_unlock) begin
            mode_d = MODE_FAIL_SAFE;
          end else if (wdog_timeout) begin
            mode_d = MODE_FAIL_SAFE;
          end
        end
        MODE_STANDBY: begin
          if (wake_hit) begin
            mode_d = MODE_FAIL_SAFE;
          end else if (din == '0) begin
            mode_d = MODE_SLEEP2;
          end
        end
        MODE_SLEEP2: begin
          if (wake_hit) begin
            mode_d = MODE_FAIL_SAFE;
          end else if (din != '0) begin
            mode_d = MODE_STANDBY;
          end
        end
        default: begin
          mode_d = MODE_RESET;
        end
      endcase
    end
  end

  // Supply indication is low in reset, so input state alone moves reset and sleep1.
  mode_type mode_limp;

  assign mode_limp = ((mode_q == MODE_RESET || mode_q == MODE_SLEEP1) && din == '0) ? MODE_SLEEP1 :
                     MODE_RESET;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q     <= MODE_RESET;
      csn_prev_q <= 1'b1;
      tgl_prev_q <= 1'b0;
    end else if (ce_i) begin
      mode_q     <= supply_low ? mode_limp : mode_d;
      csn_prev_q <= filt_q[SY_CSN];
      tgl_prev_q <= filt_q[SY_TGL];
    end
  end

  // ----------------------------------------
  // Serial registers
  // ----------------------------------------
  chan_regs_type       regs_q;
  logic [CHANNELS-1:0] latched_q;
  logic [CHANNELS-1:0] latch_set;
  logic [CHANNELS-1:0] latch_clr;
  logic                rst_bit_q;
  logic                uv_q;
  logic [CHANNELS-1:0] want;
  logic                normal;

  assign normal    = (mode_q == MODE_NORMAL);
  assign latch_set = normal ? (regs_q.latch_select_bits & shut & want) : '0;
  assign latch_clr = (accept && frame_q.cmd == CMD_CLEAR) ? frame_q.data[CHANNELS-1:0] : '0;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      regs_q    <= REGS_RESET;
      unlock_q  <= 1'b0;
      rst_bit_q <= 1'b0;
      latched_q <= '0;
    end else if (ce_i) begin
      if (clear_regs) begin
        regs_q    <= REGS_RESET;
        unlock_q  <= 1'b0;
        rst_bit_q <= 1'b0;
        latched_q <= '0;
      end else if (accept) begin
        unlock_q  <= ctrl_wr && req_unlock;
        rst_bit_q <= 1'b1;
        latched_q <= latch_set | (latched_q & ~latch_clr);
        if (ctrl_wr) begin
          regs_q.enable_bit          <= req_en;
          regs_q.standby_request_bit <= req_standby_request_bit;
        end
        if (frame_q.cmd == CMD_ON) begin
          regs_q.serial_output_on_bits <= frame_q.data[CHANNELS-1:0];
        end
        if (frame_q.cmd == CMD_DIEN) begin
          regs_q.direct_input_enable_bits <= frame_q.data[CHANNELS-1:0];
        end
        if (frame_q.cmd == CMD_PWM) begin
          regs_q.pwm_select_bits <= frame_q.data[CHANNELS-1:0];
        end
        if (frame_q.cmd == CMD_TYPE) begin
          regs_q.channel_type_bits <= frame_q.data[TYPE_CHANS-1:0];
        end
        if (frame_q.cmd == CMD_LATCH) begin
          regs_q.latch_select_bits <= frame_q.data[CHANNELS-1:0];
        end
      end else if (serial_on) begin
        latched_q <= latched_q | latch_set;
      end
    end
  end

  // ----------------------------------------
  // Battery undervoltage
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      uv_q <= 1'b0;
    end else if (ce_i) begin
      uv_q <= batt_low && !supply_low;
    end
  end

  // ----------------------------------------
  // Channel selection
  // ----------------------------------------
  logic [CHANNELS-1:0] direct_on;
  logic [CHANNELS-1:0] gate_latch;
  logic [CHANNELS-1:0] chan_d;
  logic [CHANNELS-1:0] pwm_d;
  logic                outputs_off;
  logic                limp_drive;

  assign direct_on   = (regs_q.direct_input_enable_bits & din) | regs_q.serial_output_on_bits;
  assign limp_drive  = (mode_q == MODE_RESET) || (mode_q == MODE_FAIL_SAFE)
                       || (mode_q == MODE_STANDBY);
  assign want        = normal ? direct_on : (limp_drive ? din : '0);
  assign gate_latch  = normal ? latched_q : '0;
  assign outputs_off = uv_q;
  assign chan_d      = outputs_off ? '0 : (want & ~shut & ~gate_latch);
  assign pwm_d       = normal ? (chan_d & regs_q.pwm_select_bits) : '0;

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      channel_output_o            <= '0;
      pwm_run_o                   <= '0;
      light_diode_mode_o          <= '0;
      mode_o                      <= MODE_RESET;
      reset_status_o              <= 1'b0;
      battery_undervoltage_flag_o <= 1'b0;
      serial_active_o             <= 1'b0;
      diag_available_o            <= 1'b0;
      current_sense_enable_o      <= 1'b0;
      latched_off_o               <= '0;
    end else if (ce_i) begin
      channel_output_o            <= chan_d;
      pwm_run_o                   <= pwm_d;
      light_diode_mode_o          <= regs_q.channel_type_bits;
      mode_o                      <= mode_q;
      reset_status_o              <= rst_bit_q;
      battery_undervoltage_flag_o <= uv_q;
      serial_active_o             <= serial_on;
      diag_available_o            <= serial_on;
      current_sense_enable_o      <= normal && !uv_q;
      latched_off_o               <= gate_latch;
    end
  end

endmodule : driver_mode_ctrl

// File: bench/spi_host_model.sv
`timescale 1ns/1ns
// --------
// Serial host and chip select driver
// --------
module spi_host_model (
  // Serial link
  output logic sclk_o,
  output logic mosi_o,
  output logic chip_select_low_o
);
  import driver_mode_pkg::*;

  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    chip_select_low_o = 1'b1;
  end

  // Sends one whole frame MSB first; the clock runs only inside the frame.
  task automatic send(input serial_frame_type frame);
    #13;
    chip_select_low_o = 1'b0;
    #40;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      mosi_o = frame[i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    #40;
    chip_select_low_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : send

  // Holds chip select low with no clock, as a wake request.
  task automatic hold_low(input int ns);
    chip_select_low_o = 1'b0;
    #ns;
    chip_select_low_o = 1'b1;
  endtask : hold_low
endmodule : spi_host_model

// File: bench/driver_mode_ctrl_asserts.sv
`timescale 1ns/1ns
// --------
// Mode and output checks
// --------
module driver_mode_checker (
  // Clock and reset
  input wire logic                                 ref_clk_i,
  input wire logic                                 rstn_i,
  // Watched signals
  input wire logic                                 logic_supply_low_i,
  input wire logic [driver_mode_pkg::CHANNELS-1:0] channel_output_o,
  input wire logic [driver_mode_pkg::CHANNELS-1:0] pwm_run_o,
  input wire driver_mode_pkg::mode_type            mode_o,
  input wire logic                                 reset_status_o,
  input wire logic                                 battery_undervoltage_flag_o,
  input wire logic                                 serial_active_o,
  input wire logic                                 diag_available_o,
  input wire logic                                 current_sense_enable_o,
  input wire logic [driver_mode_pkg::CHANNELS-1:0] latched_off_o
);
  import driver_mode_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_sleeping;
    (mode_o == MODE_SLEEP1 || mode_o == MODE_SLEEP2) [*2];
  endsequence
  sequence s_resetting;
    (mode_o == MODE_RESET) [*2];
  endsequence
  sequence s_uv_held;
    battery_undervoltage_flag_o [*2];
  endsequence
  sequence s_supply_drop;
    $rose(logic_supply_low_i) ##1 logic_supply_low_i [*8];
  endsequence

  a_sleep_outputs_off: assert property (s_sleeping |-> channel_output_o == '0)
    else $error("output on in sleep");
  a_reset_bit_low: assert property (s_resetting |-> !reset_status_o)
    else $error("reset bit set in reset mode");
  a_serial_by_mode: assert property (serial_active_o == (mode_o inside {MODE_FAIL_SAFE, MODE_NORMAL}))
    else $error("serial activity wrong for mode");
  a_diag_follows: assert property (diag_available_o == serial_active_o)
    else $error("diagnostics wrong for mode");
  a_sense_normal: assert property (current_sense_enable_o |-> mode_o == MODE_NORMAL && !battery_undervoltage_flag_o)
    else $error("sense enabled out of normal");
  a_undervolt_off: assert property (s_uv_held |-> channel_output_o == '0)
    else $error("output on in undervoltage");
  a_pwm_in_normal: assert property (pwm_run_o != '0 |-> mode_o == MODE_NORMAL && (pwm_run_o & ~channel_output_o) == '0)
    else $error("pwm run without channel on");
  a_latch_held_off: assert property ((latched_off_o & channel_output_o) == '0)
    else $error("latched channel is on");
  a_normal_entry: assert property (mode_o == MODE_NORMAL && $past(mode_o) != MODE_NORMAL |-> $past(mode_o) == MODE_FAIL_SAFE)
    else $error("normal entered from wrong mode");
  a_standby_entry: assert property (mode_o == MODE_STANDBY && $past(mode_o) != MODE_STANDBY |-> $past(mode_o) inside {MODE_FAIL_SAFE, MODE_NORMAL, MODE_SLEEP2})
    else $error("standby entered from wrong mode");
  a_sleep1_entry: assert property (mode_o == MODE_SLEEP1 && $past(mode_o) != MODE_SLEEP1 |-> $past(mode_o) == MODE_RESET)
    else $error("sleep 1 entered from wrong mode");
  a_sleep2_entry: assert property (mode_o == MODE_SLEEP2 && $past(mode_o) != MODE_SLEEP2 |-> $past(mode_o) == MODE_STANDBY)
    else $error("sleep 2 entered from wrong mode");
  a_supply_reset: assert property (s_supply_drop |-> mode_o inside {MODE_RESET, MODE_SLEEP1})
    else $error("no reset on supply loss");
endmodule : driver_mode_checker

bind driver_mode_ctrl driver_mode_checker driver_mode_checker_inst (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .logic_supply_low_i(logic_supply_low_i),
  .channel_output_o(channel_output_o), .pwm_run_o(pwm_run_o), .mode_o(mode_o),
  .reset_status_o(reset_status_o), .battery_undervoltage_flag_o(battery_undervoltage_flag_o),
  .serial_active_o(serial_active_o), .diag_available_o(diag_available_o),
  .current_sense_enable_o(current_sense_enable_o), .latched_off_o(latched_off_o)
);

// File: bench/driver_mode_ctrl_tb.sv
`timescale 1ns/1ns
// --------
// Mode controller bench
// --------
module driver_mode_ctrl_tb;
  import driver_mode_pkg::*;

  localparam int WD_CYC   = 1000;
  localparam int WAKE_CYC = 600;

  logic                  ref_clk_i, rstn_i, sclk, mosi, csn_low, supply_low, batt_low, ce;
  logic                  rst_stat, uv_flag, sense;
  logic [CHANNELS-1:0]   overtemp, power_limit, din, chan_out, pwm_run, latched;
  logic [CHANNELS-1:0]   on_bits, dien_bits, pwm_bits;
  logic [TYPE_CHANS-1:0] diode;
  mode_type              mode;
  logic [31:0]           lfsr_q;
  int                    error_cnt, check_count, cycles;

  driver_mode_ctrl #(.WATCHDOG_CYCLES(WD_CYC), .WAKE_CYCLES(WAKE_CYC)) driver_mode_ctrl_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .sclk_i(sclk), .mosi_i(mosi),
    .chip_select_low_i(csn_low), .logic_supply_low_i(supply_low), .battery_undervoltage_i(batt_low),
    .overtemp_shutdown_i(overtemp), .power_limit_shutdown_i(power_limit), .direct_input_i(din),
    .channel_output_o(chan_out), .pwm_run_o(pwm_run), .light_diode_mode_o(diode), .mode_o(mode),
    .reset_status_o(rst_stat), .battery_undervoltage_flag_o(uv_flag), .serial_active_o(),
    .diag_available_o(), .current_sense_enable_o(sense), .latched_off_o(latched)
  );

  spi_host_model spi_host_model_inst (.sclk_o(sclk), .mosi_o(mosi), .chip_select_low_o(csn_low));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [3:0] rnd4();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[3:0];
  endfunction : rnd4

  function automatic logic [3:0] exp_out(input logic [3:0] on, input logic [3:0] dien, input logic [3:0] d);
    return (dien & d) | on;
  endfunction : exp_out

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_mode(input mode_type exp);
    chk({1'b0, mode}, {1'b0, exp});
  endtask : chk_mode

  task automatic frame(input logic [7:0] cmd, input logic [7:0] data);
    spi_host_model_inst.send({cmd, data});
    cyc(12);
  endtask : frame

  task automatic go_normal();
    frame(CMD_CONTROL, 8'h04);
    frame(CMD_CONTROL, 8'h01);
    chk_mode(MODE_NORMAL);
  endtask : go_normal

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  initial begin
    lfsr_q = 32'h6990F227;
    {error_cnt, check_count, cycles} = '0;
    {supply_low, batt_low, overtemp, power_limit} = '0;
    ce = 1'b1;
    din = 4'h5;
    rstn_i = 1'b0;
    cyc(10);
    rstn_i = 1'b1;
    cyc(12);
    chk_mode(MODE_FAIL_SAFE);
    chk({3'h0, rst_stat}, 4'h0);
    repeat (4) begin
      din = rnd4();
      cyc(8);
      chk(chan_out, din);
    end
    ce = 1'b0;
    din = ~din;
    cyc(10);
    chk(chan_out, ~din);
    ce = 1'b1;
    cyc(8);
    chk(chan_out, din);
    frame(CMD_ON, 8'h00);
    chk({3'h0, rst_stat}, 4'h1);
    frame(CMD_LATCH, 8'h0F);
    din = 4'hF;
    overtemp = 4'hF;
    cyc(10);
    chk(chan_out, 4'h0);
    overtemp = 4'h0;
    cyc(10);
    chk(chan_out, 4'hF);
    frame(CMD_CONTROL, 8'h04);
    frame(CMD_DIEN, 8'h00);
    frame(CMD_CONTROL, 8'h01);
    chk_mode(MODE_FAIL_SAFE);
    go_normal();
    chk({3'h0, sense}, 4'h1);
    repeat (6) begin
      {on_bits, dien_bits, pwm_bits, din} = {rnd4(), rnd4(), rnd4(), rnd4()};
      frame(CMD_ON, {4'h0, on_bits});
      frame(CMD_DIEN, {4'h0, dien_bits});
      frame(CMD_PWM, {4'h0, pwm_bits});
      chk(chan_out, exp_out(on_bits, dien_bits, din));
      chk(pwm_run, exp_out(on_bits, dien_bits, din) & pwm_bits);
    end
    din = 4'h9;
    frame(CMD_TYPE, 8'h02);
    chk({2'h0, diode}, 4'h2);
    frame(CMD_DIEN, 8'h00);
    frame(CMD_PWM, 8'h00);
    frame(CMD_ON, 8'h03);
    frame(CMD_LATCH, 8'h01);
    {overtemp, power_limit} = {4'h1, 4'h2};
    cyc(10);
    chk(chan_out, 4'h0);
    {overtemp, power_limit} = '0;
    cyc(10);
    chk(chan_out, 4'h2);
    chk(latched, 4'h1);
    frame(CMD_CLEAR, 8'h01);
    chk(chan_out, 4'h3);
    batt_low = 1'b1;
    cyc(10);
    chk(chan_out, 4'h0);
    chk({3'h0, uv_flag}, 4'h1);
    chk_mode(MODE_NORMAL);
    batt_low = 1'b0;
    cyc(10);
    chk(chan_out, 4'h3);
    chk({3'h0, uv_flag}, 4'h0);
    frame(CMD_SW_RESET, 8'h00);
    chk_mode(MODE_FAIL_SAFE);
    chk({3'h0, rst_stat}, 4'h0);
    chk({2'h0, diode}, 4'h0);
    go_normal();
    frame(CMD_CONTROL, 8'h00);
    chk_mode(MODE_FAIL_SAFE);
    go_normal();
    frame(CMD_CONTROL, 8'h04);
    chk_mode(MODE_NORMAL);
    frame(CMD_CONTROL, 8'h02);
    chk_mode(MODE_STANDBY);
    spi_host_model_inst.hold_low(WAKE_CYC * 8 + 800);
    cyc(12);
    chk_mode(MODE_FAIL_SAFE);
    go_normal();
    cyc(WD_CYC - 100);
    chk_mode(MODE_NORMAL);
    cyc(200);
    chk_mode(MODE_FAIL_SAFE);
    frame(CMD_TYPE, 8'h03);
    frame(CMD_CONTROL, 8'h04);
    frame(CMD_CONTROL, 8'h02);
    chk_mode(MODE_STANDBY);
    frame(CMD_TYPE, 8'h00);
    chk({2'h0, diode}, 4'h3);
    chk(chan_out, din);
    din = 4'h0;
    cyc(10);
    chk_mode(MODE_SLEEP2);
    din = 4'h8;
    cyc(10);
    chk_mode(MODE_STANDBY);
    din = 4'h0;
    cyc(10);
    spi_host_model_inst.hold_low(WAKE_CYC * 8 + 800);
    cyc(12);
    chk_mode(MODE_FAIL_SAFE);
    chk({2'h0, diode}, 4'h3);
    din = 4'h6;
    supply_low = 1'b1;
    cyc(10);
    chk_mode(MODE_RESET);
    chk(chan_out, 4'h6);
    chk({2'h0, diode}, 4'h0);
    frame(CMD_TYPE, 8'h03);
    chk({2'h0, diode}, 4'h0);
    din = 4'h0;
    cyc(10);
    chk_mode(MODE_SLEEP1);
    din = 4'h1;
    cyc(10);
    chk_mode(MODE_RESET);
    din = 4'h0;
    cyc(10);
    supply_low = 1'b0;
    cyc(10);
    chk_mode(MODE_FAIL_SAFE);
    end_of_test();
  end
endmodule : driver_mode_ctrl_tb
